// File: bench/lbcs_engine_checker.sv
`timescale 1ns/1ps
module lbcs_engine_checker
	import lbcs_pkg::*;
#(
	parameter int LUMA_W = 8
) (
	input wire logic              i_clk,
	input wire logic              i_srst,
	input wire logic [7:0]        i_addr,
	input wire logic [31:0]       i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [31:0]       o_rdata,
	input wire logic              i_system_streaming_state,
	input wire logic              i_spatial_transform_stage_sel,
	input wire logic              i_pix_valid,
	input wire logic [LUMA_W-1:0] i_pix_luma,
	input wire logic [15:0]       i_pix_col,
	input wire logic [15:0]       i_pix_row,
	input wire logic              i_frame_start,
	input wire logic              i_frame_end,
	input wire logic              o_busy,
	input wire logic              o_result_valid
);
	// ****************************************
	// helper: start request seen at an edge
	// ****************************************
	logic start_w;
	logic start_q;
	assign start_w = i_wr && i_addr == LBCS_A_CMD && i_wdata[15:0] == LBCS_CMD_START;
	always_ff @(posedge i_clk) begin
		start_q <= !i_srst && start_w && i_system_streaming_state && !o_busy;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_idle_soon;
		##[1:3] !o_busy;
	endsequence
	// ****************************************
	// properties
	// ****************************************
	a_rdata_quiet: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	a_status_flags: assert property (i_rd && i_addr == LBCS_A_STATUS |=> o_rdata[1:0] == {$past(o_result_valid), $past(o_busy)})
		else $error("status flags differ from outputs");
	a_unmapped_zero: assert property (i_rd && i_addr > LBCS_A_STATUS |=> o_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_start_refused: assert property (start_w && !i_system_streaming_state && !o_busy |=> !o_busy)
		else $error("start taken while not streaming");
	a_busy_cause: assert property ($rose(o_busy) |-> start_q)
		else $error("run began without an acceptable start");
	a_start_clears: assert property ($rose(o_busy) |-> !o_result_valid)
		else $error("old result still valid during new run");
	a_result_kept: assert property (o_result_valid && !o_busy && !start_w |=> o_result_valid)
		else $error("held result lost");
	a_stream_abort: assert property (o_busy && !i_system_streaming_state |-> s_idle_soon)
		else $error("run kept going without streaming");
	a_valid_at_end: assert property ($rose(o_result_valid) |-> $fell(o_busy))
		else $error("result valid without run end");
endmodule
bind lbcs_engine lbcs_engine_checker #(.LUMA_W(LUMA_W)) u_lbcs_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_system_streaming_state(i_system_streaming_state),
	.i_spatial_transform_stage_sel(i_spatial_transform_stage_sel), .i_pix_valid(i_pix_valid),
	.i_pix_luma(i_pix_luma), .i_pix_col(i_pix_col), .i_pix_row(i_pix_row), .i_frame_start(i_frame_start),
	.i_frame_end(i_frame_end), .o_busy(o_busy), .o_result_valid(o_result_valid)
);

// File: bench/lbcs_engine_tb.sv
`timescale 1ns/1ps
module lbcs_engine_tb
	import lbcs_pkg::*;
;
	logic        clk, srst, wstb, rstb, strm, sel, pv, fs, fe, busy, rv, go, crs;
	logic [7:0]  addr, pl;
	logic [31:0] wdata, rdata;
	logic [15:0] pc, pr;
	int          n_mismatch, total_checks, cyc;
	lbcs_engine #(.LUMA_W(8)) DUT (
		.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wstb), .i_rd(rstb), .o_rdata(rdata),
		.i_system_streaming_state(strm), .i_spatial_transform_stage_sel(sel), .i_pix_valid(pv),
		.i_pix_luma(pl), .i_pix_col(pc), .i_pix_row(pr), .i_frame_start(fs), .i_frame_end(fe),
		.o_busy(busy), .o_result_valid(rv)
	);
	// cross placed so two-pixel bins and one-pixel bins give different centres
	lbcs_pix_src #(.CX(4), .CY(8)) u_src (.i_clk(clk), .i_go(go), .i_cross(crs), .o_valid(pv), .o_luma(pl),
		.o_col(pc), .o_row(pr), .o_fs(fs), .o_fe(fe));
	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wstb <= 1'b1;
		@(posedge clk);
		wstb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rstb <= 1'b1;
		@(posedge clk);
		rstb <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic cmd(input logic [15:0] c, input logic [7:0] st);
		logic [31:0] d;
		wr_reg(LBCS_A_CMD, {16'h0000, c});
		rd_reg(LBCS_A_CMD, d);
		chk("status code", {24'h000000, st}, {24'h000000, d[7:0]});
	endtask
	task automatic cfg(input logic [7:0] op, mb, input logic [15:0] c0, c1, r0, r1, th, an);
		wr_reg(LBCS_A_PARAM0, {16'h0000, mb, op});
		wr_reg(LBCS_A_PARAM1, {c1, c0});
		wr_reg(LBCS_A_PARAM2, {r1, r0});
		wr_reg(LBCS_A_PARAM3, {an, th});
	endtask
	task automatic frame_done();
		// go stays high so frames keep coming while a search zooms in
		go <= 1'b1;
		@(posedge clk);
		#1;
		// bounded so a stuck run ends the test rather than the bench
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		chk("busy", 32'h0, {31'h0, busy});
		@(posedge clk);
		go <= 1'b0;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] d;
		wr_reg(8'h24, 32'hFFFF_FFFF);
		for (int a = 0; a <= 36; a += 4) begin
			rd_reg(8'(a), d);
			chk("reset word", LBCS_RST_WORD, d);
		end
		$display("test reset done");
	endtask
	task automatic t_refuse();
		logic [7:0]  bo[5] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
		logic [15:0] bt[5] = '{16'h0032, 16'h0000, 16'h0065, 16'h0032, 16'h0032};
		logic [15:0] ba[5] = '{16'h0003, 16'h0003, 16'h0003, 16'h0000, 16'h0008};
		strm <= 1'b0;
		cfg(LBCS_OP_LUMA, 8'h02, 16'h0000, 16'h000F, 16'h0000, 16'h000F, 16'h0032, 16'h0003);
		cmd(LBCS_CMD_START, LBCS_ST_BUSY);
		cmd(LBCS_CMD_FETCH, LBCS_ST_BUSY);
		strm <= 1'b1;
		cmd(LBCS_CMD_FETCH, LBCS_ST_NOENT);
		for (int i = 0; i < 5; i++) begin
			cfg(bo[i], 8'h02, 16'h0000, 16'h000F, 16'h0000, 16'h000F, bt[i], ba[i]);
			cmd(LBCS_CMD_START, LBCS_ST_INVAL);
		end
		cmd(16'h8B02, LBCS_ST_NOCMD);
		$display("test refuse done");
	endtask
	task automatic t_luma();
		logic [31:0] d;
		logic [31:0] ec[8];
		logic [31:0] er[8];
		for (int b = 0; b < 8; b++) begin
			ec[b] = 32'h0;
			er[b] = 32'h0;
		end
		for (int r = 1; r <= 16; r++) begin
			for (int c = 2; c <= 17; c++) begin
				ec[(c - 2) / 2] += 32'((c + 3 * r) & 255);
				er[(r - 1) / 2] += 32'((c + 3 * r) & 255);
			end
		end
		crs <= 1'b0;
		// minimum bin far too large on purpose: luma mode must not use it
		cfg(LBCS_OP_LUMA, 8'hFF, 16'h0002, 16'h0011, 16'h0001, 16'h0010, 16'h0064, 16'h0007);
		cmd(LBCS_CMD_START, LBCS_ST_NOERR);
		chk("busy", 32'h1, {31'h0, busy});
		rd_reg(LBCS_A_STATUS, d);
		chk("status word", 32'h0000_0105, d);
		cmd(LBCS_CMD_START, LBCS_ST_BUSY);
		cmd(LBCS_CMD_FETCH, LBCS_ST_BUSY);
		frame_done();
		chk("result valid", 32'h1, {31'h0, rv});
		for (int ax = 1; ax <= 2; ax++) begin
			for (int b = 0; b <= 8; b++) begin
				wr_reg(LBCS_A_RDSEL, {8'h00, 8'(ax), 8'(b), LBCS_OP_LUMA});
				cmd(LBCS_CMD_FETCH, (b == 8) ? LBCS_ST_RANGE : LBCS_ST_NOERR);
				if (b < 8) begin
					rd_reg(LBCS_A_RESP, d);
					chk("bin sum", (ax == 1) ? ec[b] : er[b], d);
				end
			end
		end
		wr_reg(LBCS_A_RDSEL, {24'h000000, LBCS_OP_CROSS});
		cmd(LBCS_CMD_FETCH, LBCS_ST_NOENT);
		$display("test luma done");
	endtask
	task automatic t_cross();
		logic [31:0] d;
		crs <= 1'b1;
		cfg(LBCS_OP_CROSS, 8'h02, 16'h0000, 16'h000F, 16'h0000, 16'h000F, 16'h0001, 16'h0001);
		cmd(LBCS_CMD_START, LBCS_ST_NOERR);
		frame_done();
		wr_reg(LBCS_A_RDSEL, {24'h000000, LBCS_OP_CROSS});
		cmd(LBCS_CMD_FETCH, LBCS_ST_NOERR);
		rd_reg(LBCS_A_RESP, d);
		// two-pixel bins only resolve the cross to the bin centre
		chk("cross centre", {16'h0009, 16'h0005}, d);
		// one-pixel minimum bin forces a second, zoomed frame
		cfg(LBCS_OP_CROSS, 8'h01, 16'h0000, 16'h000F, 16'h0000, 16'h000F, 16'h0001, 16'h0001);
		cmd(LBCS_CMD_START, LBCS_ST_NOERR);
		frame_done();
		cmd(LBCS_CMD_FETCH, LBCS_ST_NOERR);
		rd_reg(LBCS_A_RESP, d);
		chk("zoomed centre", {16'h0008, 16'h0004}, d);
		$display("test cross done");
	endtask
	task automatic t_abort();
		logic [31:0] d;
		cfg(LBCS_OP_LUMA, 8'h02, 16'h0000, 16'h000F, 16'h0000, 16'h000F, 16'h0032, 16'h0003);
		cmd(LBCS_CMD_START, LBCS_ST_NOERR);
		strm <= 1'b0;
		frame_done();
		chk("result valid", 32'h0, {31'h0, rv});
		strm <= 1'b1;
		cmd(LBCS_CMD_FETCH, LBCS_ST_NOENT);
		// output path not sourced from the transform stage: nothing may be summed
		sel <= 1'b0;
		cmd(LBCS_CMD_START, LBCS_ST_NOERR);
		frame_done();
		sel <= 1'b1;
		chk("result valid", 32'h1, {31'h0, rv});
		wr_reg(LBCS_A_RDSEL, {8'h00, LBCS_AXIS_COL, 8'h00, LBCS_OP_LUMA});
		cmd(LBCS_CMD_FETCH, LBCS_ST_NOERR);
		rd_reg(LBCS_A_RESP, d);
		chk("unsourced sum", 32'h0, d);
		$display("test abort done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ****************************************
	// clock, timeout and main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		{srst, wstb, rstb, go, crs} = 5'h10;
		strm = 1'b1;
		sel = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_refuse();
		t_luma();
		t_cross();
		t_abort();
		summarize();
	end
endmodule

// File: bench/lbcs_pix_src.sv
`timescale 1ns/1ps
// ****************************************
// pixel source in place of the transform stage output
// ****************************************
module lbcs_pix_src #(
	parameter int CX = 5,
	parameter int CY = 9
) (
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic        i_cross,
	output logic             o_valid,
	output logic [7:0]       o_luma,
	output logic [15:0]      o_col,
	output logic [15:0]      o_row,
	output logic             o_fs,
	output logic             o_fe
);
	initial begin
		o_valid = 1'b0;
		o_fs = 1'b0;
		o_fe = 1'b0;
		o_luma = 8'h00;
		o_col = 16'h0000;
		o_row = 16'h0000;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				o_fs <= 1'b1;
				@(posedge i_clk);
				o_fs <= 1'b0;
				// frame is 18x18 so pixels beyond the window are offered too
				for (int r = 0; r < 18; r++) begin
					for (int c = 0; c < 18; c++) begin
						o_valid <= 1'b1;
						o_col <= 16'(c);
						o_row <= 16'(r);
						o_luma <= i_cross ? ((c == CX || r == CY) ? 8'hC8 : 8'h10) : 8'(c + 3 * r);
						o_fe <= (r == 17 && c == 17);
						@(posedge i_clk);
					end
				end
				o_valid <= 1'b0;
				o_fe <= 1'b0;
			end
			// idle lines keep moving so a stale pixel never looks real
			o_luma <= ~o_luma;
			o_col <= ~o_col;
		end
	end
endmodule

// File: hw/lbcs_engine.sv
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - start code 0x8B00 configures and enables engine, returns at once
// - fetch code 0x8B01 completes in one cycle with response values
// - operation selector is 8 bits: 0 cross search, 1 luma recording
// - start fields: op +0, min bin +1, window coordinates at +2..+8
// - edge threshold is 16-bit percent, accepted only 1 to 100
// - max rotation is 16-bit degrees, accepted only 1 to 7
// - start refused busy while running or not streaming
// - cross search shrinks window round brightest bin until min bin size
// - centre reported unclamped, may lie outside search window
// - luma recording ignores min bin size, uses only window coordinates
// - luma mode splits window into 8 row bands and 8 column strips
// - each bin sums pixel luma into 24-bit accumulator
// - bin sums held after run for later fetch
// - pixels from transform stage, gathered only while streaming and sourced
// - only bright cross on dark background is searched for
// - fetch carries bin index 0..7 at +1, axis at +2, 1 means columns
// - luma fetch returns bin sum as 32-bit word at offset zero
// - cross fetch returns centre column at zero and row at two
// - fetch busy while running or not streaming, range error for bad bin
module lbcs_engine
	import lbcs_pkg::*;
#(
	parameter int LUMA_W = 8
) (
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	input  wire logic              i_system_streaming_state,
	input  wire logic              i_spatial_transform_stage_sel,
	input  wire logic              i_pix_valid,
	input  wire logic [LUMA_W-1:0] i_pix_luma,
	input  wire logic [15:0]       i_pix_col,
	input  wire logic [15:0]       i_pix_row,
	input  wire logic              i_frame_start,
	input  wire logic              i_frame_end,
	output logic                   o_busy,
	output logic                   o_result_valid
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (LUMA_W < 1 || LUMA_W > LBCS_SUM_W) begin : g_bad_luma
		$error("LUMA_W must lie between 1 and the sum width");
	end

	// ************************************************************
	// functions
	// ************************************************************
	// bin of a coordinate; 8 means before the window start or at or past the end of bin 7
	function automatic logic [3:0] bin_of(input logic [15:0] p, input logic [15:0] st,
		input logic [15:0] sz);
		logic [16:0] off;
		logic [3:0]  n;
		off = {1'b0, p} - {1'b0, st};
		n = 4'h8;
		if (!off[16]) begin
			n = 4'h0;
			for (int k = 1; k <= LBCS_NBINS; k++) begin
				if (off >= 17'(k) * {1'b0, sz}) begin
					n = 4'(k);
				end
			end
		end
		return n;
	endfunction
	// brightest bin; ties go to the lowest index
	function automatic logic [2:0] argmax(input lbcs_sums_t s);
		logic [2:0] b;
		b = 3'h0;
		for (int k = 1; k < LBCS_NBINS; k++) begin
			if (s[k] > s[b]) begin
				b = 3'(k);
			end
		end
		return b;
	endfunction

	// ************************************************************
	// parameter registers
	// ************************************************************
	logic [31:0]  param0_r;
	logic [31:0]  param1_r;
	logic [31:0]  param2_r;
	logic [31:0]  param3_r;
	logic [31:0]  rdsel_r;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			param0_r <= LBCS_RST_WORD;
			param1_r <= LBCS_RST_WORD;
			param2_r <= LBCS_RST_WORD;
			param3_r <= LBCS_RST_WORD;
			rdsel_r  <= LBCS_RST_WORD;
		end else if (i_wr) begin
			case (i_addr)
				LBCS_A_PARAM0: param0_r <= i_wdata;
				LBCS_A_PARAM1: param1_r <= i_wdata;
				LBCS_A_PARAM2: param2_r <= i_wdata;
				LBCS_A_PARAM3: param3_r <= i_wdata;
				LBCS_A_RDSEL:  rdsel_r  <= i_wdata;
				default: ;
			endcase
		end
	end
	logic [7:0]  p_op;
	logic [7:0]  p_minbin;
	logic [15:0] p_xs;
	logic [15:0] p_xe;
	logic [15:0] p_ys;
	logic [15:0] p_ye;
	logic [15:0] p_thr;
	logic [15:0] p_ang;
	logic [7:0]  f_op;
	logic [7:0]  f_bin;
	logic [7:0]  f_axis;
	assign p_op     = param0_r[LBCS_F_B0 +: 8];
	assign p_minbin = param0_r[LBCS_F_B1 +: 8];
	assign p_xs     = param1_r[LBCS_F_B0 +: 16];
	assign p_xe     = param1_r[LBCS_F_HI +: 16];
	assign p_ys     = param2_r[LBCS_F_B0 +: 16];
	assign p_ye     = param2_r[LBCS_F_HI +: 16];
	assign p_thr    = param3_r[LBCS_F_B0 +: 16];
	assign p_ang    = param3_r[LBCS_F_HI +: 16];
	assign f_op     = rdsel_r[LBCS_F_B0 +: 8];
	assign f_bin    = rdsel_r[LBCS_F_B1 +: 8];
	assign f_axis   = rdsel_r[LBCS_F_B2 +: 8];

	// ************************************************************
	// command decode
	// ************************************************************
	lbcs_state_t state_r;
	logic        result_valid_r;
	logic [7:0]  result_op_r;
	logic        cmd_wr;
	logic        busy;
	logic        start_req;
	logic        start_bad;
	logic        start_go;
	logic        fetch_req;
	logic [16:0] p_xlen;
	logic [16:0] p_ylen;
	assign cmd_wr    = i_wr && (i_addr == LBCS_A_CMD);
	assign busy      = (state_r != LBCS_IDLE);
	assign start_req = cmd_wr && (i_wdata[15:0] == LBCS_CMD_START);
	assign fetch_req = cmd_wr && (i_wdata[15:0] == LBCS_CMD_FETCH);
	assign p_xlen    = {1'b0, p_xe} - {1'b0, p_xs} + 17'h00001;
	assign p_ylen    = {1'b0, p_ye} - {1'b0, p_ys} + 17'h00001;
	// a window narrower than 8 pixels would give zero-sized bins
	assign start_bad = (p_op != LBCS_OP_CROSS && p_op != LBCS_OP_LUMA)
		|| p_thr < LBCS_THR_MIN || p_thr > LBCS_THR_MAX
		|| p_ang < LBCS_ANG_MIN || p_ang > LBCS_ANG_MAX
		|| p_xlen[16] || p_ylen[16] || p_xlen < 17'h00008 || p_ylen < 17'h00008;
	assign start_go  = start_req && !busy && i_system_streaming_state && !start_bad;

	// ************************************************************
	// working window and sizes
	// ************************************************************
	logic [15:0] win_xs_r;
	logic [15:0] win_xe_r;
	logic [15:0] win_ys_r;
	logic [15:0] win_ye_r;
	logic [7:0]  run_op_r;
	logic [7:0]  minbin_r;
	logic [16:0] xlen;
	logic [16:0] ylen;
	logic [15:0] xsz;
	logic [15:0] ysz;
	assign xlen = {1'b0, win_xe_r} - {1'b0, win_xs_r} + 17'h00001;
	assign ylen = {1'b0, win_ye_r} - {1'b0, win_ys_r} + 17'h00001;
	assign xsz  = 16'(xlen >> LBCS_BIN_SH);
	assign ysz  = 16'(ylen >> LBCS_BIN_SH);

	// ************************************************************
	// accumulators
	// ************************************************************
	lbcs_sums_t row_sum;
	lbcs_sums_t col_sum;
	logic       pix_ok;
	logic       sums_clr;
	logic [3:0] row_bin;
	logic [3:0] col_bin;
	assign pix_ok   = (state_r == LBCS_GATHER) && i_pix_valid
		&& i_system_streaming_state && i_spatial_transform_stage_sel;
	assign sums_clr = (state_r == LBCS_WAIT) && i_frame_start;
	assign row_bin  = bin_of(i_pix_row, win_ys_r, ysz);
	assign col_bin  = bin_of(i_pix_col, win_xs_r, xsz);
	for (genvar g = 0; g < LBCS_NBINS; g++) begin : g_acc
		always_ff @(posedge i_clk) begin
			if (i_srst || sums_clr) begin
				row_sum[g] <= '0;
				col_sum[g] <= '0;
			end else if (pix_ok) begin
				// a pixel counts in its row bin only inside the column span, and vice versa
				if (row_bin == 4'(g) && col_bin != 4'h8) begin
					row_sum[g] <= row_sum[g] + LBCS_SUM_W'(i_pix_luma);
				end
				if (col_bin == 4'(g) && row_bin != 4'h8) begin
					col_sum[g] <= col_sum[g] + LBCS_SUM_W'(i_pix_luma);
				end
			end
		end
	end

	// ************************************************************
	// centre search step
	// ************************************************************
	logic [2:0]  bx;
	logic [2:0]  by;
	logic [16:0] cx;
	logic [16:0] cy;
	logic [16:0] min_w;
	logic [16:0] nxw;
	logic [16:0] nyw;
	logic [16:0] nxs;
	logic [16:0] nys;
	logic        zoom_done;
	assign bx        = argmax(col_sum);
	assign by        = argmax(row_sum);
	assign cx        = {1'b0, win_xs_r} + 17'({1'b0, xsz} * bx) + 17'(xsz >> 1);
	assign cy        = {1'b0, win_ys_r} + 17'({1'b0, ysz} * by) + 17'(ysz >> 1);
	assign min_w     = 17'({minbin_r, 3'h0});
	assign zoom_done = (xsz <= 16'(minbin_r)) && (ysz <= 16'(minbin_r));
	assign nxw       = ((xlen >> 1) > min_w) ? (xlen >> 1) : min_w;
	assign nyw       = ((ylen >> 1) > min_w) ? (ylen >> 1) : min_w;
	// window start floors at zero; the centre itself is never clamped
	assign nxs       = (cx > (nxw >> 1)) ? cx - (nxw >> 1) : 17'h00000;
	assign nys       = (cy > (nyw >> 1)) ? cy - (nyw >> 1) : 17'h00000;

	// ************************************************************
	// engine state machine
	// ************************************************************
	logic [15:0] ctr_x_r;
	logic [15:0] ctr_y_r;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= LBCS_IDLE;
		end else begin
			case (state_r)
				LBCS_IDLE:   if (start_go) state_r <= LBCS_WAIT;
				LBCS_WAIT:   if (!i_system_streaming_state) state_r <= LBCS_IDLE;
					else if (i_frame_start) state_r <= LBCS_GATHER;
				LBCS_GATHER: if (!i_system_streaming_state) state_r <= LBCS_IDLE;
					else if (i_frame_end) state_r <= LBCS_EVAL;
				LBCS_EVAL:   if (run_op_r == LBCS_OP_LUMA || zoom_done) state_r <= LBCS_IDLE;
					else state_r <= LBCS_WAIT;
				default:     state_r <= LBCS_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			win_xs_r <= 16'h0000;
			win_xe_r <= 16'h0000;
			win_ys_r <= 16'h0000;
			win_ye_r <= 16'h0000;
			run_op_r <= LBCS_OP_CROSS;
			minbin_r <= 8'h01;
		end else if (start_go) begin
			win_xs_r <= p_xs;
			win_xe_r <= p_xe;
			win_ys_r <= p_ys;
			win_ye_r <= p_ye;
			run_op_r <= p_op;
			minbin_r <= (p_minbin == 8'h00) ? 8'h01 : p_minbin;
		end else if (state_r == LBCS_EVAL && run_op_r == LBCS_OP_CROSS && !zoom_done) begin
			win_xs_r <= nxs[15:0];
			win_xe_r <= 16'(nxs + nxw - 17'h00001);
			win_ys_r <= nys[15:0];
			win_ye_r <= 16'(nys + nyw - 17'h00001);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			result_valid_r <= 1'b0;
			result_op_r    <= LBCS_OP_CROSS;
			ctr_x_r        <= 16'h0000;
			ctr_y_r        <= 16'h0000;
		end else if (start_go) begin
			result_valid_r <= 1'b0;
			result_op_r    <= p_op;
		end else if (state_r == LBCS_EVAL) begin
			if (run_op_r == LBCS_OP_LUMA) begin
				result_valid_r <= 1'b1;
			end else if (zoom_done) begin
				result_valid_r <= 1'b1;
				ctr_x_r        <= cx[15:0];
				ctr_y_r        <= cy[15:0];
			end
		end
	end

	// ************************************************************
	// command status and response
	// ************************************************************
	logic [7:0]  cmd_status_r;
	logic [31:0] resp_r;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cmd_status_r <= LBCS_ST_NOERR;
			resp_r       <= LBCS_RST_WORD;
		end else if (start_req) begin
			if (busy || !i_system_streaming_state) begin
				cmd_status_r <= LBCS_ST_BUSY;
			end else if (start_bad) begin
				cmd_status_r <= LBCS_ST_INVAL;
			end else begin
				cmd_status_r <= LBCS_ST_NOERR;
			end
		end else if (fetch_req) begin
			if (busy || !i_system_streaming_state) begin
				cmd_status_r <= LBCS_ST_BUSY;
			end else if (!result_valid_r || f_op != result_op_r) begin
				cmd_status_r <= LBCS_ST_NOENT;
			end else if (f_op == LBCS_OP_LUMA && f_bin > LBCS_BIN_MAX) begin
				cmd_status_r <= LBCS_ST_RANGE;
			end else begin
				cmd_status_r <= LBCS_ST_NOERR;
				if (f_op == LBCS_OP_LUMA) begin
					resp_r <= (f_axis == LBCS_AXIS_COL) ? 32'(col_sum[f_bin[2:0]])
						: 32'(row_sum[f_bin[2:0]]);
				end else begin
					resp_r <= {ctr_y_r, ctr_x_r};
				end
			end
		end else if (cmd_wr) begin
			cmd_status_r <= LBCS_ST_NOCMD;
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= LBCS_RST_WORD;
		end else if (i_rd) begin
			case (i_addr)
				LBCS_A_CMD:    o_rdata <= 32'(cmd_status_r);
				LBCS_A_PARAM0: o_rdata <= param0_r;
				LBCS_A_PARAM1: o_rdata <= param1_r;
				LBCS_A_PARAM2: o_rdata <= param2_r;
				LBCS_A_PARAM3: o_rdata <= param3_r;
				LBCS_A_RDSEL:  o_rdata <= rdsel_r;
				LBCS_A_RESP:   o_rdata <= resp_r;
				LBCS_A_STATUS: o_rdata <= {16'h0000, result_op_r, 4'h0, state_r,
					result_valid_r, busy};
				default:       o_rdata <= LBCS_RST_WORD;
			endcase
		end else begin
			o_rdata <= LBCS_RST_WORD;
		end
	end
	assign o_busy         = busy;
	assign o_result_valid = result_valid_r;
endmodule

// File: hw/lbcs_pkg.sv
package lbcs_pkg;

	// ************************************************************
	// command codes and operation selectors
	// ************************************************************
	localparam logic [15:0] LBCS_CMD_START = 16'h8B00;
	localparam logic [15:0] LBCS_CMD_FETCH = 16'h8B01;
	localparam logic [7:0]  LBCS_OP_CROSS  = 8'h00;
	localparam logic [7:0]  LBCS_OP_LUMA   = 8'h01;
	localparam logic [7:0]  LBCS_AXIS_COL  = 8'h01;
	localparam logic [7:0]  LBCS_BIN_MAX   = 8'h07;

	// ************************************************************
	// parameter limits
	// ************************************************************
	localparam logic [15:0] LBCS_THR_MIN   = 16'h0001;
	localparam logic [15:0] LBCS_THR_MAX   = 16'h0064;
	localparam logic [15:0] LBCS_ANG_MIN   = 16'h0001;
	localparam logic [15:0] LBCS_ANG_MAX   = 16'h0007;

	// ************************************************************
	// result status codes
	// ************************************************************
	localparam logic [7:0]  LBCS_ST_NOERR  = 8'h00;
	localparam logic [7:0]  LBCS_ST_BUSY   = 8'h01;
	localparam logic [7:0]  LBCS_ST_INVAL  = 8'h02;
	localparam logic [7:0]  LBCS_ST_RANGE  = 8'h03;
	localparam logic [7:0]  LBCS_ST_NOENT  = 8'h04;
	localparam logic [7:0]  LBCS_ST_NOCMD  = 8'h05;

	// ************************************************************
	// register map (byte addresses) and field positions
	// ************************************************************
	localparam logic [7:0]  LBCS_A_CMD     = 8'h00;
	localparam logic [7:0]  LBCS_A_PARAM0  = 8'h04;
	localparam logic [7:0]  LBCS_A_PARAM1  = 8'h08;
	localparam logic [7:0]  LBCS_A_PARAM2  = 8'h0C;
	localparam logic [7:0]  LBCS_A_PARAM3  = 8'h10;
	localparam logic [7:0]  LBCS_A_RDSEL   = 8'h14;
	localparam logic [7:0]  LBCS_A_RESP    = 8'h18;
	localparam logic [7:0]  LBCS_A_STATUS  = 8'h1C;
	localparam int          LBCS_F_B0      = 0;
	localparam int          LBCS_F_B1      = 8;
	localparam int          LBCS_F_B2      = 16;
	localparam int          LBCS_F_HI      = 16;
	localparam logic [31:0] LBCS_RST_WORD  = 32'h0000_0000;

	// ************************************************************
	// bins and engine states
	// ************************************************************
	localparam int          LBCS_NBINS     = 8;
	localparam int          LBCS_SUM_W     = 24;
	localparam int          LBCS_BIN_SH    = 3;

	typedef logic [LBCS_SUM_W-1:0] lbcs_sums_t [LBCS_NBINS];

	typedef enum logic [1:0] {
		LBCS_IDLE   = 2'b00,
		LBCS_WAIT   = 2'b01,
		LBCS_GATHER = 2'b11,
		LBCS_EVAL   = 2'b10
	} lbcs_state_t;

endpackage
